/* verilog/pcc_chain.sv */
// Summary of operation
// - corrections run dark, offset, responsivity, background, gain in fixed order.
// - stored per-pixel dark value subtracted, indexed by pixel position.
// - programmable constant offset subtracted before the responsivity multiplier.
// - each pixel multiplied by its own coefficient of at least one.
// - every stage carries 12-bit pixel values.
// - background value is in 12-bit units.
`timescale 1ns/1ps
`default_nettype none
module pcc_chain (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_pix_valid,
    input wire logic i_line_start,
    input wire logic [pcc_pkg::PIX_W-1:0] i_pix,
    input wire logic i_dark_en,
    input wire logic i_resp_en,
    input wire logic [pcc_pkg::PIX_W-1:0] i_dig_offset,
    input wire logic [pcc_pkg::PIX_W-1:0] i_background,
    input wire logic [pcc_pkg::GAIN_W-1:0] i_sys_gain,
    input wire logic i_coef_we,
    input wire logic [pcc_pkg::POS_W-1:0] i_coef_addr,
    input wire logic [pcc_pkg::PIX_W-1:0] i_coef_dark,
    input wire logic [pcc_pkg::COEF_W-1:0] i_coef_resp,
    input wire logic i_roi_we,
    input wire logic [pcc_pkg::POS_W-1:0] i_region_start_pixel,
    input wire logic [pcc_pkg::POS_W-1:0] i_region_end_pixel,
    input wire logic [pcc_pkg::POS_W-1:0] i_region_end_row,
    output logic o_pix_valid,
    output logic [pcc_pkg::PIX_W-1:0] o_pix,
    output logic o_pix_in_region,
    output logic o_roi_refused,
    output logic [pcc_pkg::POS_W-1:0] o_region_start_pixel,
    output logic [pcc_pkg::POS_W-1:0] o_region_end_pixel
);
    import pcc_pkg::*;

    localparam int MW = PIX_W + COEF_W;
    localparam int CW = PIX_W + COEF_W;
    localparam logic [POS_W-1:0] POS_ONE = 12'h001;
    localparam logic [POS_W:0] POS_LIMIT = 13'h1000;

    // ----------------------------------------
    // region of interest
    // ----------------------------------------
    logic [POS_W-1:0] roi_start_q, roi_end_q;
    logic roi_refused_q;
    wire roi_ok = (i_region_start_pixel >= POS_ONE) && (i_region_end_pixel > i_region_start_pixel)
                  && ({1'b0, i_region_end_pixel} <= POS_LIMIT) && (i_region_end_row == POS_ONE);
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            roi_start_q <= POS_ONE;
            roi_end_q <= PIX_MAX;
            roi_refused_q <= 1'b0;
        end else if (i_roi_we) begin
            // bad settings kept out so the region stays consistent
            roi_refused_q <= !roi_ok;
            if (roi_ok) begin
                roi_start_q <= i_region_start_pixel;
                roi_end_q <= i_region_end_pixel;
            end
        end
    end

    // ----------------------------------------
    // pixel position and coefficient fetch
    // ----------------------------------------
    logic [POS_W-1:0] pos_q;
    wire [POS_W-1:0] cur_pos = i_line_start ? POS_ZERO : pos_q;
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pos_q <= POS_ZERO;
        end else if (i_pix_valid) begin
            pos_q <= cur_pos + POS_ONE;
        end
    end

    logic [CW-1:0] coef_rd;
    pcc_coef_mem #(.DW(CW), .AW(POS_W)) u_mem (
        .i_clk(i_clk),
        .i_we(i_coef_we),
        .i_waddr(i_coef_addr),
        .i_wdata({i_coef_dark, i_coef_resp}),
        .i_raddr(cur_pos),
        .o_rdata(coef_rd)
    );

    // ----------------------------------------
    // stage 0: align with memory read
    // ----------------------------------------
    logic [PIX_W-1:0] s0_q, s1_q, s2_q, s3_q, s4_q, s5_q;
    logic [POS_W-1:0] p0_q;
    logic [PIPE_DEPTH-1:0] v_q;
    wire [PIX_W-1:0] dark_val = coef_rd[CW-1:COEF_W];
    // coefficients below one are raised to one so no pixel is attenuated
    wire [COEF_W-1:0] resp_raw = coef_rd[COEF_W-1:0];
    wire [COEF_W-1:0] resp_val = (i_resp_en && resp_raw >= COEF_ONE) ? resp_raw : COEF_ONE;

    // stage 1: dark subtraction, clamped at zero
    wire [PIX_W-1:0] dark_sub = i_dark_en ? dark_val : PIX_ZERO;
    wire [PIX_W-1:0] s1_d = (s0_q > dark_sub) ? s0_q - dark_sub : PIX_ZERO;
    // stage 2: constant offset
    wire [PIX_W-1:0] s2_d = (s1_q > i_dig_offset) ? s1_q - i_dig_offset : PIX_ZERO;
    // stage 3: responsivity, 4.12 fixed point
    logic [COEF_W-1:0] resp_q, resp_d1_q;
    wire [MW-1:0] resp_prod = s2_q * resp_d1_q;
    wire [MW-COEF_FRAC-1:0] resp_sh = resp_prod[MW-1:COEF_FRAC];
    wire [PIX_W-1:0] s3_d = (|resp_sh[MW-COEF_FRAC-1:PIX_W]) ? PIX_MAX : resp_sh[PIX_W-1:0];
    // stage 4: background in 12-bit units
    wire [PIX_W-1:0] s4_d = (s3_q > i_background) ? s3_q - i_background : PIX_ZERO;
    // stage 5: system gain, 4096 is unity
    localparam int GW = PIX_W + GAIN_W;
    wire [GW-1:0] gain_prod = s4_q * i_sys_gain;
    wire [GW-GAIN_FRAC-1:0] gain_sh = gain_prod[GW-1:GAIN_FRAC];
    wire [PIX_W-1:0] s5_d = (|gain_sh[GW-GAIN_FRAC-1:PIX_W]) ? PIX_MAX : gain_sh[PIX_W-1:0];

    logic [POS_W-1:0] p1_q, p2_q, p3_q, p4_q;
    logic roi_q;
    wire in_roi = (p4_q + POS_ONE >= roi_start_q) && (p4_q + POS_ONE <= roi_end_q);

    // ----------------------------------------
    // pipeline: fixed stage order
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            v_q <= '0;
            s0_q <= PIX_ZERO;
            s1_q <= PIX_ZERO;
            s2_q <= PIX_ZERO;
            s3_q <= PIX_ZERO;
            s4_q <= PIX_ZERO;
            s5_q <= PIX_ZERO;
            resp_q <= COEF_ONE;
            p0_q <= POS_ZERO;
            p1_q <= POS_ZERO;
            p2_q <= POS_ZERO;
            p3_q <= POS_ZERO;
            p4_q <= POS_ZERO;
            roi_q <= 1'b0;
        end else begin
            v_q <= {v_q[PIPE_DEPTH-2:0], i_pix_valid};
            s0_q <= i_pix;
            p0_q <= cur_pos;
            s1_q <= s1_d;
            s2_q <= s2_d;
            resp_q <= resp_val;
            s3_q <= s3_d;
            s4_q <= s4_d;
            s5_q <= s5_d;
            p1_q <= p0_q;
            p2_q <= p1_q;
            p3_q <= p2_q;
            p4_q <= p3_q;
            roi_q <= in_roi;
        end
    end

    // note: resp_q is fetched one stage early and re-timed to meet s2_q
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            resp_d1_q <= COEF_ONE;
        end else begin
            resp_d1_q <= resp_q;
        end
    end

    assign o_pix_valid = v_q[PIPE_DEPTH-1];
    assign o_pix = s5_q;
    assign o_pix_in_region = roi_q;
    assign o_roi_refused = roi_refused_q;
    assign o_region_start_pixel = roi_start_q;
    assign o_region_end_pixel = roi_end_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    chk_bad_roi_kept: assert property (i_roi_we && !roi_ok |=> roi_refused_q && $stable(roi_start_q))
        else $error("refused region changed");
    chk_row_forced: assert property (i_roi_we && i_region_end_row != POS_ONE |=> roi_refused_q)
        else $error("row not one accepted");
    chk_roi_order: assert property (roi_end_q > roi_start_q)
        else $error("region end not above start");
    chk_valid_lat: assert property (i_pix_valid |-> ##6 o_pix_valid)
        else $error("pixel latency wrong");
    chk_dark_clamp: assert property (s0_q <= dark_sub |=> s1_q == PIX_ZERO)
        else $error("dark subtraction wrapped");
    chk_offset_sub: assert property (s1_q > i_dig_offset |=> s2_q == $past(s1_q) - $past(i_dig_offset))
        else $error("offset subtraction wrong");
    chk_resp_min: assert property (resp_val >= COEF_ONE)
        else $error("coefficient below one");
    chk_gain_unity: assert property (i_sys_gain == GAIN_UNITY && $stable(i_sys_gain) |=> s5_q == $past(s4_q))
        else $error("unity gain altered pixel");
    chk_bg_clamp: assert property (s3_q <= i_background |=> s4_q == PIX_ZERO)
        else $error("background wrapped");
    chk_dark_sub: assert property (s0_q > dark_sub |=> s1_q == $past(s0_q) - $past(dark_sub))
        else $error("dark subtraction wrong");
    chk_resp_unity: assert property (resp_d1_q == COEF_ONE |=> s3_q == $past(s2_q))
        else $error("unity coefficient altered pixel");
    chk_resp_sat: assert property ((|resp_sh[MW-COEF_FRAC-1:PIX_W]) |=> s3_q == PIX_MAX)
        else $error("responsivity product wrapped");
    chk_gain_sat: assert property ((|gain_sh[GW-GAIN_FRAC-1:PIX_W]) |=> s5_q == PIX_MAX)
        else $error("gain product wrapped");
    // line start must restart the coefficient index
    sequence seq_line_first;
        i_pix_valid && i_line_start;
    endsequence
    sequence seq_line_next;
        ##1 (pos_q == POS_ONE);
    endsequence
    chk_pos_restart: assert property (seq_line_first |-> seq_line_next)
        else $error("position not restarted");
endmodule : pcc_chain
`default_nettype wire

/* verilog/pcc_pkg.sv */
`default_nettype none
package pcc_pkg;
    localparam int PIX_W = 12;
    localparam int POS_W = 12;
    localparam int NUM_PIXELS = 4096;
    localparam int COEF_W = 16;
    localparam int COEF_FRAC = 12;
    localparam int GAIN_W = 16;
    localparam int GAIN_FRAC = 12;
    localparam logic [PIX_W-1:0] PIX_MAX = 12'hFFF;
    localparam logic [COEF_W-1:0] COEF_ONE = 16'h1000;
    localparam logic [GAIN_W-1:0] GAIN_UNITY = 16'h1000;
    localparam logic [PIX_W-1:0] PIX_ZERO = 12'h000;
    localparam logic [POS_W-1:0] POS_ZERO = 12'h000;
    localparam int PIPE_DEPTH = 6;
endpackage : pcc_pkg
`default_nettype wire

/* verilog/pcc_coef_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module pcc_coef_mem #(
    parameter int DW = 28,
    parameter int AW = 12
) (
    input wire logic i_clk,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [DW-1:0] i_wdata,
    input wire logic [AW-1:0] i_raddr,
    output logic [DW-1:0] o_rdata
);
    // registered read: one cycle latency, no reset so it maps to block ram
    logic [DW-1:0] mem [0:(1<<AW)-1];
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule : pcc_coef_mem
`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pcc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic pv = 1'b0;
    logic ls = 1'b0;
    logic de = 1'b0;
    logic re = 1'b0;
    logic cwe = 1'b0;
    logic rwe = 1'b0;
    logic [11:0] pix = 12'h000, off = 12'h000, bg = 12'h000, cd = 12'h000, ca = 12'h000;
    logic [11:0] rs = 12'h000, rend = 12'h000, rrow = 12'h000;
    logic [15:0] gain = 16'h1000, cr = 16'h1000;
    logic [11:0] opix, ors, ore;
    logic ov, oin, oref;
    int err_count = 0;
    int n_checks = 0;
    always #10 clk = ~clk;
    pcc_chain i_dut (.i_clk(clk), .i_arst_n(rst_n), .i_pix_valid(pv), .i_line_start(ls), .i_pix(pix),
        .i_dark_en(de), .i_resp_en(re), .i_dig_offset(off), .i_background(bg), .i_sys_gain(gain),
        .i_coef_we(cwe), .i_coef_addr(ca), .i_coef_dark(cd), .i_coef_resp(cr), .i_roi_we(rwe),
        .i_region_start_pixel(rs), .i_region_end_pixel(rend), .i_region_end_row(rrow),
        .o_pix_valid(ov), .o_pix(opix), .o_pix_in_region(oin), .o_roi_refused(oref),
        .o_region_start_pixel(ors), .o_region_end_pixel(ore));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    task automatic roi_case(input logic [11:0] s, e, row, input logic ref_x, input logic [11:0] es, ee);
        @(posedge clk);
        rwe <= 1'b1;
        rs <= s;
        rend <= e;
        rrow <= row;
        @(posedge clk);
        rwe <= 1'b0;
        @(posedge clk);
        #1;
        check("roi_refused", 16'(oref), 16'(ref_x));
        check("region_start", 16'(ors), 16'(es));
        check("region_end", 16'(ore), 16'(ee));
    endtask : roi_case
    // single pixel at line position 0; position 1 gets the same pair so idle reads stay known
    task automatic pix_case(input logic [11:0] p, input logic den, input logic [11:0] dk, input logic ren,
        input logic [15:0] rc, input logic [11:0] o, b, input logic [15:0] g, input logic ir,
        input logic [11:0] exp);
        int n;
        @(posedge clk);
        cwe <= 1'b1;
        ca <= 12'h000;
        cd <= dk;
        cr <= rc;
        de <= den;
        re <= ren;
        off <= o;
        bg <= b;
        gain <= g;
        @(posedge clk);
        ca <= 12'h001;
        pv <= 1'b1;
        ls <= 1'b1;
        pix <= p;
        @(posedge clk);
        cwe <= 1'b0;
        pv <= 1'b0;
        ls <= 1'b0;
        for (n = 0; n < 10 && ov !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        check("latency", 16'(n), 16'(PIPE_DEPTH - 1));
        check("pix_out", 16'(opix), 16'(exp));
        check("in_region", 16'(oin), 16'(ir));
    endtask : pix_case
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_reset;
        @(posedge clk);
        #1;
        check("reset_start", 16'(ors), 16'h0001);
        check("reset_end", 16'(ore), 16'h0FFF);
        check("reset_refused", 16'(oref), 16'h0000);
        $display("test reset done");
    endtask : test_reset
    task automatic test_roi;
        roi_case(12'h00A, 12'h032, 12'h001, 1'b0, 12'h00A, 12'h032);
        roi_case(12'h000, 12'h040, 12'h001, 1'b1, 12'h00A, 12'h032);
        roi_case(12'h014, 12'h014, 12'h001, 1'b1, 12'h00A, 12'h032);
        roi_case(12'h01E, 12'h014, 12'h001, 1'b1, 12'h00A, 12'h032);
        roi_case(12'h005, 12'h03C, 12'h002, 1'b1, 12'h00A, 12'h032);
        roi_case(12'h001, 12'h002, 12'h001, 1'b0, 12'h001, 12'h002);
        $display("test roi done");
    endtask : test_roi
    task automatic test_chain;
        pix_case(12'hABC, 1'b0, 12'h064, 1'b0, 16'h1800, 12'h000, 12'h000, 16'h1000, 1'b1, 12'hABC);
        pix_case(12'h960, 1'b1, 12'h064, 1'b1, 16'h1800, 12'h032, 12'h800, 16'h2000, 1'b1, 12'hA5E);
        pix_case(12'h032, 1'b1, 12'h064, 1'b0, 16'h1000, 12'h000, 12'h000, 16'h1000, 1'b1, 12'h000);
        pix_case(12'h010, 1'b0, 12'h000, 1'b0, 16'h1000, 12'h020, 12'h000, 16'h1000, 1'b1, 12'h000);
        pix_case(12'h3E8, 1'b0, 12'h000, 1'b1, 16'h0800, 12'h000, 12'h000, 16'h1000, 1'b1, 12'h3E8);
        pix_case(12'hC00, 1'b0, 12'h000, 1'b1, 16'h2000, 12'h000, 12'h000, 16'h1000, 1'b1, 12'hFFF);
        pix_case(12'hBB8, 1'b0, 12'h000, 1'b0, 16'h1000, 12'h000, 12'h800, 16'h2000, 1'b1, 12'h770);
        pix_case(12'hFA0, 1'b0, 12'h000, 1'b0, 16'h1000, 12'h000, 12'h000, 16'h2000, 1'b1, 12'hFFF);
        $display("test chain done");
    endtask : test_chain
    // two back-to-back pixels with different coefficient pairs; position 2 kept known for idle reads
    task automatic test_index;
        @(posedge clk);
        cwe <= 1'b1;
        ca <= 12'h000;
        cd <= 12'h010;
        cr <= 16'h1000;
        de <= 1'b1;
        re <= 1'b1;
        off <= 12'h000;
        bg <= 12'h000;
        gain <= 16'h1000;
        @(posedge clk);
        ca <= 12'h001;
        cd <= 12'h020;
        cr <= 16'h2000;
        @(posedge clk);
        ca <= 12'h002;
        @(posedge clk);
        cwe <= 1'b0;
        pv <= 1'b1;
        ls <= 1'b1;
        pix <= 12'h100;
        @(posedge clk);
        ls <= 1'b0;
        @(posedge clk);
        pv <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        check("index0_valid", 16'(ov), 16'h0001);
        check("index0_pix", 16'(opix), 16'h00F0);
        @(posedge clk);
        #1;
        check("index1_valid", 16'(ov), 16'h0001);
        check("index1_pix", 16'(opix), 16'h01C0);
        check("index1_region", 16'(oin), 16'h0001);
        $display("test index done");
    endtask : test_index
    task automatic test_region;
        roi_case(12'h00A, 12'h032, 12'h001, 1'b0, 12'h00A, 12'h032);
        pix_case(12'h123, 1'b0, 12'h000, 1'b0, 16'h1000, 12'h000, 12'h000, 16'h1000, 1'b0, 12'h123);
        $display("test region done");
    endtask : test_region
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        test_reset;
        test_roi;
        test_chain;
        test_index;
        test_region;
        end_of_test;
    end
    initial begin
        repeat (3000) @(posedge clk);
        err_count++;
        end_of_test;
    end
endmodule : tb
`default_nettype wire
